// ---- hw/asram_pkg.sv ----
/*
 * Constants shared by the asynchronous static RAM host controller:
 * pin widths and timing figures in nanoseconds with derived cycle counts.
 * Assumes a 25 MHz controller clock.
 */
package asram_pkg;
    localparam int unsigned CLK_PERIOD_NS          = 40;
    localparam int unsigned ADDR_W                 = 18;
    localparam int unsigned DATA_W                 = 16;
    localparam int unsigned LANE_W                 = 8;
    // Read access: address_access_delay, worst speed grade.
    localparam int unsigned ADDRESS_ACCESS_DELAY_NS = 15;
    // Write pulse width, output float delay and data setup before write end.
    localparam int unsigned WRITE_PULSE_NS         = 10;
    localparam int unsigned OUTPUT_FLOAT_NS        = 7;
    localparam int unsigned DATA_SETUP_NS          = 7;
    // Least times round up to whole cycles; the read count takes one cycle more.
    localparam int unsigned READ_CYCLES =
        (ADDRESS_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int unsigned WRITE_PLAIN_CYCLES =
        (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WRITE_OE_CYCLES =
        (OUTPUT_FLOAT_NS + DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Read data crosses a two-flop synchroniser before it is captured.
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned CNT_W = 4;
    typedef enum logic [1:0] {ASRAM_IDLE, ASRAM_READ, ASRAM_WRITE, ASRAM_DONE} asram_state_t;
endpackage

// ---- hw/asram_host.sv ----
/*
 * Host controller that drives an asynchronous 16-bit static RAM with two
 * byte-lane selects. Accepts one request at a time and answers with a
 * one-cycle done pulse. Assumes the RAM pins are wired directly to the
 * ports and that the testbench resolves the shared data wire.
 */
`timescale 1ns/100ps
module asram_host
    import asram_pkg::*;
(
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    input  wire logic              i_req,
    input  wire logic              i_write,
    input  wire logic              i_keep_oe,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [1:0]        i_lanes,
    input  wire logic [DATA_W-1:0] i_wdata,
    output logic                   o_busy,
    output logic                   o_done,
    output logic [DATA_W-1:0]      o_rdata,
    output logic [ADDR_W-1:0]      o_addr,
    output logic                   o_chip_select_n,
    output logic                   o_write_strobe_n,
    output logic                   o_output_enable_n,
    output logic                   o_upper_lane_select_n,
    output logic                   o_lower_lane_select_n,
    output logic [DATA_W-1:0]      o_dq,
    output logic                   o_dq_oe,
    input  wire logic [DATA_W-1:0] i_dq
);
    asram_state_t      state;
    asram_state_t      next_state;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  next_cnt;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic [DATA_W-1:0] next_rdata;
    logic [ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] next_dq;
    logic              next_cs_n;
    logic              next_we_n;
    logic              next_oe_n;
    logic              next_ub_n;
    logic              next_lb_n;
    logic              next_dq_oe;
    logic              next_busy;
    logic              next_done;

    function automatic logic [CNT_W-1:0] write_len(input logic keep_oe);
        write_len = keep_oe ? CNT_W'(WRITE_OE_CYCLES) : CNT_W'(WRITE_PLAIN_CYCLES);
    endfunction

    always_comb
    begin
        next_state = state;
        next_cnt   = cnt;
        next_rdata = o_rdata;
        next_addr  = o_addr;
        next_dq    = o_dq;
        next_cs_n  = o_chip_select_n;
        next_we_n  = o_write_strobe_n;
        next_oe_n  = o_output_enable_n;
        next_ub_n  = o_upper_lane_select_n;
        next_lb_n  = o_lower_lane_select_n;
        next_dq_oe = o_dq_oe;
        next_busy  = o_busy;
        next_done  = 1'b0;
        unique case (state)
            ASRAM_IDLE:
            begin
                // A request with no lane selected is no access at all.
                if (i_req && (i_lanes != 2'h0))
                begin
                    // Address and all strobes move in the same edge.
                    next_addr = i_addr;
                    next_cs_n = 1'b0;
                    next_lb_n = ~i_lanes[0];
                    next_ub_n = ~i_lanes[1];
                    next_busy = 1'b1;
                    if (i_write)
                    begin
                        // Selects fall with the strobe, so the RAM never drives.
                        next_we_n  = 1'b0;
                        next_oe_n  = ~i_keep_oe;
                        next_dq    = i_wdata;
                        next_dq_oe = 1'b1;
                        next_cnt   = write_len(i_keep_oe);
                        next_state = ASRAM_WRITE;
                    end
                    else
                    begin
                        next_we_n  = 1'b1;
                        next_oe_n  = 1'b0;
                        // The wait covers the access delay and the synchroniser latency.
                        next_cnt   = CNT_W'(READ_CYCLES + SYNC_STAGES - 1);
                        next_state = ASRAM_READ;
                    end
                end
                else if (i_req)
                begin
                    next_done = 1'b1;
                end
            end
            ASRAM_READ:
            begin
                next_cnt = cnt - CNT_W'(1);
                if (cnt == CNT_W'(1))
                begin
                    // Only the selected lanes carry meaningful data.
                    next_rdata = dq_s2 & {{LANE_W{~o_upper_lane_select_n}},
                                          {LANE_W{~o_lower_lane_select_n}}};
                    next_state = ASRAM_DONE;
                end
            end
            ASRAM_WRITE:
            begin
                next_cnt = cnt - CNT_W'(1);
                if (cnt == CNT_W'(1))
                begin
                    // Data stays driven one more cycle as hold, so output enable must
                    // rise with the strobe or the RAM would start driving into it.
                    next_we_n  = 1'b1;
                    next_oe_n  = 1'b1;
                    next_state = ASRAM_DONE;
                end
            end
            ASRAM_DONE:
            begin
                next_cs_n  = 1'b1;
                next_oe_n  = 1'b1;
                next_ub_n  = 1'b1;
                next_lb_n  = 1'b1;
                next_dq_oe = 1'b0;
                next_busy  = 1'b0;
                next_done  = 1'b1;
                next_state = ASRAM_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        // Read data comes from pins, so it passes two flops first.
        dq_s1 <= i_dq;
        dq_s2 <= dq_s1;
        if (i_rst)
        begin
            state                 <= ASRAM_IDLE;
            cnt                   <= '0;
            o_rdata               <= '0;
            o_addr                <= '0;
            o_dq                  <= '0;
            o_chip_select_n       <= 1'b1;
            o_write_strobe_n      <= 1'b1;
            o_output_enable_n     <= 1'b1;
            o_upper_lane_select_n <= 1'b1;
            o_lower_lane_select_n <= 1'b1;
            o_dq_oe               <= 1'b0;
            o_busy                <= 1'b0;
            o_done                <= 1'b0;
        end
        else
        begin
            state                 <= next_state;
            cnt                   <= next_cnt;
            o_rdata               <= next_rdata;
            o_addr                <= next_addr;
            o_dq                  <= next_dq;
            o_chip_select_n       <= next_cs_n;
            o_write_strobe_n      <= next_we_n;
            o_output_enable_n     <= next_oe_n;
            o_upper_lane_select_n <= next_ub_n;
            o_lower_lane_select_n <= next_lb_n;
            o_dq_oe               <= next_dq_oe;
            o_busy                <= next_busy;
            o_done                <= next_done;
        end
    end

    sequence s_read_start;
        !o_chip_select_n && o_write_strobe_n && !o_output_enable_n && !$past(o_busy);
    endsequence

    a_read_no_strobe: assert property (@(posedge i_mclk) disable iff (i_rst)
        (state == ASRAM_READ) |-> o_write_strobe_n)
        else $error("write strobe low during read");
    a_read_held_low: assert property (@(posedge i_mclk) disable iff (i_rst)
        s_read_start |-> (!o_chip_select_n && !o_output_enable_n)[*3])
        else $error("read selects not held");
    a_addr_with_sel: assert property (@(posedge i_mclk) disable iff (i_rst)
        (!o_chip_select_n && !$past(o_chip_select_n)) |-> $stable(o_addr))
        else $error("address not valid at select");
    a_lane_map: assert property (@(posedge i_mclk) disable iff (i_rst)
        $fell(o_chip_select_n)
            |-> {o_upper_lane_select_n, o_lower_lane_select_n} == ~$past(i_lanes))
        else $error("lane selects do not match request");
    a_write_overlap: assert property (@(posedge i_mclk) disable iff (i_rst)
        !o_write_strobe_n |-> !o_chip_select_n
            && !(o_upper_lane_select_n && o_lower_lane_select_n))
        else $error("write strobe outside select");
    a_write_len_oe: assert property (@(posedge i_mclk) disable iff (i_rst)
        ($fell(o_write_strobe_n) && !o_output_enable_n)
            |-> (!o_write_strobe_n)[*1] ##1 o_write_strobe_n)
        else $error("write pulse length wrong");
    a_write_len_plain: assert property (@(posedge i_mclk) disable iff (i_rst)
        ($fell(o_write_strobe_n) && o_output_enable_n) |-> ##1 o_write_strobe_n)
        else $error("plain write pulse wrong");
    a_no_contention: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_dq_oe |-> !o_write_strobe_n || $past(!o_write_strobe_n))
        else $error("data driven outside write");
    a_dq_no_clash: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_dq_oe |-> !o_write_strobe_n || o_output_enable_n)
        else $error("data driven while RAM may drive");
    a_sel_with_strobe: assert property (@(posedge i_mclk) disable iff (i_rst)
        $fell(o_write_strobe_n) |-> $fell(o_chip_select_n))
        else $error("select fell before strobe");
    a_idle_quiet: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_chip_select_n |-> o_write_strobe_n && !o_dq_oe)
        else $error("activity while deselected");
    a_done_pulse: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_done |=> !o_done)
        else $error("done longer than one cycle");
endmodule

// ---- test/asram_dev_model.sv ----
/*
 * Behavioural model of the 16-bit static RAM with two byte-lane selects.
 * Assumes the host's pins are wired straight in and resolves the data wire.
 */
`timescale 1ns/100ps
module asram_dev_model
    import asram_pkg::*;
(
    input  wire logic              i_mclk,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic              i_chip_select_n,
    input  wire logic              i_write_strobe_n,
    input  wire logic              i_output_enable_n,
    input  wire logic              i_upper_lane_select_n,
    input  wire logic              i_lower_lane_select_n,
    input  wire logic [DATA_W-1:0] i_host_dq,
    input  wire logic              i_host_dq_oe,
    output logic [DATA_W-1:0]      o_dq,
    output logic                   o_clash
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] noise = 16'h5a3c;
    logic [DATA_W-1:0] bus;
    logic [DATA_W-1:0] word;
    logic [1:0]        lane_on;
    logic [1:0]        drive;
    // A floating wire must not look like a stable value; the clock only feeds this noise.
    always @(posedge i_mclk) noise <= {noise[14:0], noise[15] ^ noise[13]};
    assign lane_on = {~i_upper_lane_select_n, ~i_lower_lane_select_n};
    assign bus = i_host_dq_oe ? i_host_dq : noise;
    always @(i_addr or i_chip_select_n or i_write_strobe_n or lane_on or bus)
    begin
        word = mem.exists(i_addr) ? mem[i_addr] : 16'h0000;
        if (!i_chip_select_n && !i_write_strobe_n && lane_on != 2'h0)
        begin
            for (int k = 0; k < 2; k++)
                if (lane_on[k]) word[k*8+:8] = bus[k*8+:8];
            mem[i_addr] = word;
        end
    end
    // Write strobe high is required, so selects falling with it never drive.
    assign drive = (!i_chip_select_n && !i_output_enable_n && i_write_strobe_n) ?
                   lane_on : 2'h0;
    assign o_clash = i_host_dq_oe && (drive != 2'h0);
    // Read data follows the address after the access delay.
    assign #(ADDRESS_ACCESS_DELAY_NS) o_dq = i_host_dq_oe ? i_host_dq :
        {drive[1] ? word[15:8] : noise[15:8], drive[0] ? word[7:0] : noise[7:0]};
endmodule

// ---- test/tb_asram_host.sv ----
/*
 * Self-checking bench for the static RAM host controller.
 * Assumes the device model above stands on the pins.
 */
`timescale 1ns/100ps
module tb_asram_host import asram_pkg::*; ();
    logic              i_mclk = 0, i_rst = 1, i_req = 0, i_write = 0, i_keep_oe = 0;
    logic [ADDR_W-1:0] i_addr = '0, addr_pins;
    logic [1:0]        i_lanes = '0;
    logic [DATA_W-1:0] i_wdata = '0, rdata, dq_out, dq_bus, last_rd = '0;
    logic              busy, done, cs_n, we_n, oe_n, ub_n, lb_n, dq_oe, clash;
    logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]];
    int                num_errors = 0, cmp_count = 0, cycles = 0;
    asram_host uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(i_req), .i_write(i_write),
        .i_keep_oe(i_keep_oe), .i_addr(i_addr), .i_lanes(i_lanes), .i_wdata(i_wdata),
        .o_busy(busy), .o_done(done), .o_rdata(rdata), .o_addr(addr_pins),
        .o_chip_select_n(cs_n), .o_write_strobe_n(we_n), .o_output_enable_n(oe_n),
        .o_upper_lane_select_n(ub_n), .o_lower_lane_select_n(lb_n), .o_dq(dq_out),
        .o_dq_oe(dq_oe), .i_dq(dq_bus));
    asram_dev_model dev (.i_mclk(i_mclk), .i_addr(addr_pins), .i_chip_select_n(cs_n),
        .i_write_strobe_n(we_n), .i_output_enable_n(oe_n), .i_upper_lane_select_n(ub_n),
        .i_lower_lane_select_n(lb_n), .i_host_dq(dq_out), .i_host_dq_oe(dq_oe),
        .o_dq(dq_bus), .o_clash(clash));
    initial forever #20 i_mclk = ~i_mclk;
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Two operations take well under 20 cycles; this ceiling covers every op with margin.
    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] exp_rd(input logic [17:0] a, input logic [1:0] ln);
        logic [15:0] w;
        w = ref_mem.exists(a) ? ref_mem[a] : 16'h0000;
        return {ln[1] ? w[15:8] : 8'h00, ln[0] ? w[7:0] : 8'h00};
    endfunction
    task automatic op(input logic wr, input logic [1:0] ln, input logic [17:0] a,
                      input logic [15:0] d, input logic ko);
        int n;
        int exp_n;
        n = 0;
        exp_n = (ln == 2'h0) ? 0 : wr ? (ko ? WRITE_OE_CYCLES : WRITE_PLAIN_CYCLES) + 1
                                      : READ_CYCLES + 2;
        @(posedge i_mclk);
        {i_req, i_write, i_lanes, i_addr, i_wdata, i_keep_oe} <= {1'b1, wr, ln, a, d, ko};
        @(posedge i_mclk);
        i_req <= 1'b0;
        #1;
        if (ln != 2'h0) chk({cs_n, ub_n, lb_n, we_n, oe_n, addr_pins},
            {1'b0, ~ln, ~wr, wr ? ~ko : 1'b0, a});
        else chk({ub_n, lb_n}, 2'h3);
        while (done !== 1'b1 && n < 20)
        begin
            if (!wr) chk(we_n, 1'b1);
            chk(clash, 1'b0);
            @(posedge i_mclk);
            #1;
            n++;
        end
        chk(n, exp_n);
        chk({done, busy}, 2'h2);
        // A request with no lane leaves the last read data in place.
        if (!wr && ln != 2'h0) last_rd = exp_rd(a, ln);
        if (!wr) chk(rdata, last_rd);
        else if (ln != 2'h0) ref_mem[a] = exp_rd(a, ~ln) | (d & {{8{ln[1]}}, {8{ln[0]}}});
    endtask
    initial
    begin
        void'($urandom(32'h89b1));
        repeat (10) @(posedge i_mclk);
        i_rst <= 1'b0;
        op(1, 2'h3, 18'h3ffff, 16'hbeef, 1);
        op(1, 2'h2, 18'h3ffff, 16'h1200, 0);
        op(1, 2'h0, 18'h3ffff, 16'h0000, 1);
        op(0, 2'h3, 18'h3ffff, 16'h0000, 0);
        op(0, 2'h1, 18'h3ffff, 16'h0000, 0);
        op(0, 2'h0, 18'h3ffff, 16'h0000, 0);
        $display("directed test done");
        repeat (100) op(1'($urandom), 2'($urandom), 18'($urandom % 16), 16'($urandom),
                        1'($urandom));
        $display("random test done");
        tally_and_finish();
    end
endmodule
